// ---- hdl/afc_pkg.sv ----
package afc_pkg;
	// register map
	localparam logic [7:0] ANALOG_CTRL_OFFSET = 8'h06;
	localparam logic [7:0] RESERVED_SEVEN_OFFSET = 8'h07;
	localparam logic [7:0] FAULT_OFFSET = 8'h08;
	// output stage configuration fields
	localparam int PB_ENABLE_BIT = 7;
	localparam int RATE_MSB = 6;
	localparam int RATE_LSB = 4;
	localparam int GAIN_MSB = 3;
	localparam int GAIN_LSB = 2;
	localparam int CH_SEL_BIT = 1;
	localparam int KEEP_BIT = 0;
	localparam logic [7:0] ANALOG_CTRL_RESET = 8'h51;
	// fault register fields
	localparam int OC_THR_MSB = 5;
	localparam int OC_THR_LSB = 4;
	localparam int CLK_ERR_BIT = 3;
	localparam int OC_BIT = 2;
	localparam int DC_BIT = 1;
	localparam int OT_BIT = 0;
	localparam logic [1:0] OC_THR_RESET = 2'h0;
	// analog gain codes
	localparam logic [1:0] GAIN_RESERVED = 2'h3;
	// fault input synchroniser depth
	localparam int SYNC_STAGES = 2;
	typedef enum logic [0:0] {
		AFC_RUN = 1'b0,
		AFC_HALT = 1'b1
	} afc_run_type;
endpackage

// ---- hdl/afc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module afc_regs
	import afc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	// sample rate class from the audio port: high for 88.2/96 kHz
	input wire logic double_speed_i,
	// raw fault detector levels
	input wire logic clock_fault_i,
	input wire logic overcurrent_fault_i,
	input wire logic dc_offset_fault_i,
	input wire logic overtemp_fault_i,
	// speaker shutdown pin, active low
	input wire logic speaker_shutdown_n_i,
	// decoded controls toward the output stage
	output logic parallel_bridge_mode_o,
	output logic bridge_tied_mode_o,
	output logic parallel_channel_select_o,
	output logic [4:0] switch_multiple_o,
	output logic switch_halve_o,
	output logic [1:0] gain_step_o,
	output logic [1:0] overcurrent_threshold_o,
	output logic [6:0] trip_level_percent_o,
	output logic output_enable_o
);
	// all block state except the synchroniser stages in one record
	typedef struct packed {
		logic [7:0] analog_ctrl;
		logic [1:0] oc_thr;
		logic overcurrent_flag;
		logic dc_offset_flag;
		logic overtemp_flag;
		logic sd_prev;
		logic [1:0] settle;
		afc_run_type run;
		logic [7:0] rd_data;
		logic rd_valid;
	} afc_state_type;
	afc_state_type state;
	afc_state_type next_state;
	logic [4:0] fault_sync;
	logic clock_error_flag;
	logic sd_sync;
	logic sd_toggle;
	logic [2:0] rate_code;
	logic [4:0] raw_levels;
	logic sd_armed;
	logic [7:0] fault_word;

	// pin levels in synchroniser bit order, shutdown pin on top
	assign raw_levels[4] = speaker_shutdown_n_i;
	assign raw_levels[3] = clock_fault_i;
	assign raw_levels[2] = overcurrent_fault_i;
	assign raw_levels[1] = dc_offset_fault_i;
	assign raw_levels[0] = overtemp_fault_i;

	// every fault and shutdown pin level passes two flops before any logic reads it
	afc_sync #(
		.WIDTH(5)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(raw_levels),
		.sync_o(fault_sync)
	);

	// synchronised pin levels
	assign sd_sync = fault_sync[4];
	assign clock_error_flag = fault_sync[3];
	// toggle detector arms only once sd_prev holds a real pin level,
	// so an idle-high shutdown pin gives no false toggle after reset
	assign sd_armed = (state.settle == 2'(SYNC_STAGES + 1));
	assign sd_toggle = sd_armed && (sd_sync ^ state.sd_prev);
	// switching-rate code field
	assign rate_code = state.analog_ctrl[RATE_MSB:RATE_LSB];
	// fault register read word; reserved bits 7:6 read as zero
	assign fault_word = {2'b00, state.oc_thr, clock_error_flag, state.overcurrent_flag,
		state.dc_offset_flag, state.overtemp_flag};

	// register writes, sticky fault flags and run state
	always_comb begin
		next_state = state;
		next_state.sd_prev = sd_sync;
		// settle cycles after reset, counted once and then held
		if (!sd_armed) begin
			next_state.settle = state.settle + 2'h1;
		end
		// read strobe answered one cycle later
		next_state.rd_valid = rd_en_i;
		// host writes; fault flags are not writable
		if (wr_en_i) begin
			unique case (addr_i)
				ANALOG_CTRL_OFFSET: begin
					// gain code 11 is stored as written; the host must never send it
					next_state.analog_ctrl = wr_data_i;
				end
				FAULT_OFFSET: begin
					next_state.oc_thr = wr_data_i[OC_THR_MSB:OC_THR_LSB];
				end
				default: begin
					// reserved offset 0x07 and unmapped writes are dropped
				end
			endcase
		end
		// shutdown toggle clears latches; a fault in the same cycle wins
		if (sd_toggle) begin
			next_state.overcurrent_flag = 1'b0;
			next_state.dc_offset_flag = 1'b0;
			next_state.overtemp_flag = 1'b0;
		end
		// synchronised fault levels set their sticky flags
		if (fault_sync[2]) begin
			next_state.overcurrent_flag = 1'b1;
		end
		if (fault_sync[1]) begin
			next_state.dc_offset_flag = 1'b1;
		end
		if (fault_sync[0]) begin
			next_state.overtemp_flag = 1'b1;
		end
		// any latched fault stops the output stage
		next_state.run = (next_state.overcurrent_flag || next_state.dc_offset_flag
			|| next_state.overtemp_flag) ? AFC_HALT : AFC_RUN;
		// read mux; reserved offset 0x07 and unmapped read as zero
		next_state.rd_data = 8'h00;
		if (rd_en_i) begin
			unique case (addr_i)
				ANALOG_CTRL_OFFSET: begin
					next_state.rd_data = state.analog_ctrl;
				end
				FAULT_OFFSET: begin
					next_state.rd_data = fault_word;
				end
				default: begin
				end
			endcase
		end
	end

	// state register with synchronous reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state.analog_ctrl <= ANALOG_CTRL_RESET;
			state.oc_thr <= OC_THR_RESET;
			state.overcurrent_flag <= 1'b0;
			state.dc_offset_flag <= 1'b0;
			state.overtemp_flag <= 1'b0;
			state.sd_prev <= 1'b0;
			state.settle <= 2'h0;
			state.run <= AFC_RUN;
			state.rd_data <= 8'h00;
			state.rd_valid <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// operating mode, channel and gain controls
	always_comb begin
		parallel_bridge_mode_o = state.analog_ctrl[PB_ENABLE_BIT];
		bridge_tied_mode_o = ~state.analog_ctrl[PB_ENABLE_BIT];
		parallel_channel_select_o = state.analog_ctrl[CH_SEL_BIT];
		gain_step_o = state.analog_ctrl[GAIN_MSB:GAIN_LSB];
	end

	// double speed halves the switching frequency of any code
	assign switch_halve_o = double_speed_i;

	// switching-rate code to frame clock multiple
	always_comb begin
		unique case (rate_code)
			3'h0: switch_multiple_o = 5'd6;
			3'h1: switch_multiple_o = 5'd8;
			3'h2: switch_multiple_o = 5'd10;
			3'h3: switch_multiple_o = 5'd12;
			3'h4: switch_multiple_o = 5'd14;
			3'h5: switch_multiple_o = 5'd16;
			3'h6: switch_multiple_o = 5'd20;
			3'h7: switch_multiple_o = 5'd24;
		endcase
	end

	// threshold code to trip level in percent of nominal
	always_comb begin
		overcurrent_threshold_o = state.oc_thr;
		unique case (state.oc_thr)
			2'h0: trip_level_percent_o = 7'd100;
			2'h1: trip_level_percent_o = 7'd75;
			2'h2: trip_level_percent_o = 7'd50;
			2'h3: trip_level_percent_o = 7'd25;
		endcase
	end

	// clock error halts without latching
	assign output_enable_o = (state.run == AFC_RUN) && !clock_error_flag;

	// registered read answer
	assign rd_data_o = state.rd_data;
	assign rd_valid_o = state.rd_valid;
endmodule
`default_nettype wire

// ---- hdl/afc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for asynchronous fault levels
module afc_sync #(
	parameter int WIDTH = 5
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} afc_sync_state_type;
	afc_sync_state_type state;
	afc_sync_state_type next_state;

	// first stage feeds only the second
	always_comb begin
		next_state.meta = async_i;
		next_state.sync = state.meta;
	end

	// both stages clear on reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_o = state.sync;
endmodule
`default_nettype wire

// ---- test/afc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// host controller on the register port
module afc_host
	import afc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [7:0] rd_data_i,
	output logic wr_en_o = 1'b0,
	output logic rd_en_o = 1'b0,
	output logic [7:0] addr_o = 8'h00,
	output logic [7:0] wr_data_o = 8'h00
);
	// single byte write, released data lines show inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == RESERVED_SEVEN_OFFSET) return;
		if (a == ANALOG_CTRL_OFFSET) d[KEEP_BIT] = 1'b1;
		if (a == ANALOG_CTRL_OFFSET && d[3:2] == GAIN_RESERVED) d[3:2] = 2'h0;
		@(posedge ref_clk_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wr_data_o <= d;
		@(posedge ref_clk_i);
		wr_en_o <= 1'b0;
		wr_data_o <= ~d;
	endtask
	// single byte read, data taken two edges after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge ref_clk_i);
		rd_en_o <= 1'b0;
		addr_o <= ~a;
		@(posedge ref_clk_i);
		d = rd_data_i;
	endtask
endmodule
`default_nettype wire

// ---- test/afc_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// decode and timing checks on the register block
module afc_regs_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic rd_en_i,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic double_speed_i,
	input wire logic clock_fault_i,
	input wire logic overcurrent_fault_i,
	input wire logic parallel_bridge_mode_o,
	input wire logic bridge_tied_mode_o,
	input wire logic [4:0] switch_multiple_o,
	input wire logic switch_halve_o,
	input wire logic [1:0] overcurrent_threshold_o,
	input wire logic [6:0] trip_level_percent_o,
	input wire logic output_enable_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// output stage stopped
	sequence halt_s;
		!output_enable_o;
	endsequence
	// static decodes
	mode_pair_a: assert property (bridge_tied_mode_o != parallel_bridge_mode_o)
		else $error("bridge modes not inverse");
	rate_code_a: assert property (switch_multiple_o inside {6, 8, 10, 12, 14, 16, 20, 24})
		else $error("switch multiple off table");
	speed_half_a: assert property (switch_halve_o == double_speed_i)
		else $error("halving not following speed");
	trip_scale_a: assert property (trip_level_percent_o == 7'd100 - 7'd25 * overcurrent_threshold_o)
		else $error("trip level wrong");
	// read handshake
	read_answer_a: assert property (rd_en_i |=> rd_valid_o)
		else $error("read not answered");
	read_quiet_a: assert property (!rd_valid_o |-> rd_data_o == 8'h00)
		else $error("read data not idle");
	// faults stop the output stage
	oc_halt_a: assert property ($rose(overcurrent_fault_i) |-> ##[1:3] halt_s)
		else $error("overcurrent did not halt");
	clk_halt_a: assert property ($rose(clock_fault_i) |-> ##[1:3] halt_s)
		else $error("clock fault did not halt");
endmodule
bind afc_regs afc_regs_chk i_chk (.ref_clk_i, .rst_i, .rd_en_i, .rd_data_o, .rd_valid_o,
	.double_speed_i, .clock_fault_i, .overcurrent_fault_i, .parallel_bridge_mode_o,
	.bridge_tied_mode_o, .switch_multiple_o, .switch_halve_o, .overcurrent_threshold_o,
	.trip_level_percent_o, .output_enable_o);
`default_nettype wire

// ---- test/amp_analog_fault_config_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module amp_analog_fault_config_regs_test;
	import afc_pkg::*;
	logic ref_clk_i = 0, rst_i = 1, double_speed_i = 0, speaker_shutdown_n_i = 1, clock_fault_i = 0;
	logic wr_en_i, rd_en_i, rd_valid_o, parallel_bridge_mode_o, bridge_tied_mode_o;
	logic parallel_channel_select_o, switch_halve_o, output_enable_o;
	logic [7:0] addr_i, wr_data_i, rd_data_o, v, r;
	logic [4:0] switch_multiple_o;
	logic [1:0] gain_step_o, overcurrent_threshold_o;
	logic [6:0] trip_level_percent_o;
	logic [2:0] lf = 3'h0;
	wire overtemp_fault_i, dc_offset_fault_i, overcurrent_fault_i;
	int fail_count = 0, comparisons = 0, cyc = 0;
	int mult[8] = '{6, 8, 10, 12, 14, 16, 20, 24};
	assign {overcurrent_fault_i, dc_offset_fault_i, overtemp_fault_i} = {lf[0], lf[1], lf[2]};
	afc_regs i_afc_regs (.ref_clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i, .rd_data_o,
		.rd_valid_o, .double_speed_i, .clock_fault_i, .overcurrent_fault_i, .dc_offset_fault_i,
		.overtemp_fault_i, .speaker_shutdown_n_i, .parallel_bridge_mode_o, .bridge_tied_mode_o,
		.parallel_channel_select_o, .switch_multiple_o, .switch_halve_o, .gain_step_o,
		.overcurrent_threshold_o, .trip_level_percent_o, .output_enable_o);
	afc_host i_afc_host (.ref_clk_i, .rd_data_i(rd_data_o), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
		.addr_o(addr_i), .wr_data_o(wr_data_i));
	// clock and hang guard
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		i_afc_host.rd(ANALOG_CTRL_OFFSET, r);
		chk("ctrl reset", ANALOG_CTRL_RESET, r);
		for (int k = 0; k < 8; k++) begin
			v = {k[0], k[2:0], 2'(k % 3), k[1], 1'b1};
			i_afc_host.wr(ANALOG_CTRL_OFFSET, v);
			i_afc_host.rd(ANALOG_CTRL_OFFSET, r);
			chk("ctrl", v, r);
			chk("multiple", 8'(mult[k]), {3'b0, switch_multiple_o});
			chk("ctl out", {3'h0, v[7], ~v[7], v[1], v[3:2]}, {3'h0, parallel_bridge_mode_o,
				bridge_tied_mode_o, parallel_channel_select_o, gain_step_o});
		end
		double_speed_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		chk("halve", 8'h01, {6'b0, rd_valid_o, switch_halve_o});
		for (int t = 0; t < 4; t++) begin
			i_afc_host.wr(FAULT_OFFSET, {2'b11, 2'(t), 4'hF});
			i_afc_host.rd(FAULT_OFFSET, r);
			chk("fault reg", {2'b00, 2'(t), 4'h0}, r);
			chk("trip", 8'(100 - 25 * t), {1'b0, trip_level_percent_o});
			chk("threshold", 8'(t), {6'b0, overcurrent_threshold_o});
		end
		for (int i = 0; i < 4; i++) begin
			clock_fault_i <= (i == 3);
			lf <= 3'(1 << i);
			repeat (2) @(posedge ref_clk_i);
			i_afc_host.rd(FAULT_OFFSET, r);
			chk("raised", (i == 3) ? 8'h08 : 8'(4 >> i), r & 8'h0F);
			chk("halted", 8'h00, {7'b0, output_enable_o});
			lf <= 3'h0;
			clock_fault_i <= 1'b0;
			repeat (4) @(posedge ref_clk_i);
			i_afc_host.rd(FAULT_OFFSET, r);
			chk("latched", (i == 3) ? 8'h00 : 8'(4 >> i), r & 8'h0F);
			speaker_shutdown_n_i <= ~speaker_shutdown_n_i;
			repeat (4) @(posedge ref_clk_i);
			i_afc_host.rd(FAULT_OFFSET, r);
			chk("cleared", 8'h30, r);
			chk("resumed", 8'h01, {7'b0, output_enable_o});
		end
		// a shutdown toggle while a fault still stands clears nothing
		lf <= 3'h1;
		repeat (4) @(posedge ref_clk_i);
		speaker_shutdown_n_i <= ~speaker_shutdown_n_i;
		repeat (4) @(posedge ref_clk_i);
		i_afc_host.rd(FAULT_OFFSET, r);
		chk("set wins", 8'h34, r);
		lf <= 3'h0;
		speaker_shutdown_n_i <= ~speaker_shutdown_n_i;
		repeat (4) @(posedge ref_clk_i);
		i_afc_host.rd(FAULT_OFFSET, r);
		chk("set cleared", 8'h30, r);
		// a second reset mid-run restores every field
		rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		i_afc_host.rd(ANALOG_CTRL_OFFSET, r);
		chk("ctrl rearm", ANALOG_CTRL_RESET, r);
		i_afc_host.rd(FAULT_OFFSET, r);
		chk("fault rearm", 8'h00, r);
		i_afc_host.rd(8'h0A, r);
		chk("unmapped", 8'h00, r);
		stop_test();
	end
endmodule
`default_nettype wire
